// ---- rtl/rscr_pkg.sv ----
// Purpose: Constants for the regulator start-up control register bank.
// Assumes: 8-bit sub-addressed command registers behind a serial engine.
// Notes: Offsets are sub-addresses; reset values are all zero.
package rscr_pkg;
    localparam logic [7:0] RSCR_ADDR_RAIL_ENABLE = 8'h10;
    localparam logic [7:0] RSCR_ADDR_STARTUP = 8'h12;
    localparam logic [7:0] RSCR_ADDR_REF_SLEW = 8'h20;
    localparam logic [7:0] RSCR_RESET_RAIL_ENABLE = 8'h00;
    localparam logic [7:0] RSCR_RESET_STARTUP = 8'h00;
    localparam logic [7:0] RSCR_RESET_REF_SLEW = 8'h00;
    localparam int RSCR_SW_CTRL_BIT = 7;
    localparam int RSCR_HS_MASK_BIT = 7;
    localparam int RSCR_NUM_RAILS = 7;
    // Fault persistence before hard shutdown, and its cycle count at 100 MHz
    localparam int RSCR_CLK_MHZ = 100;
    localparam int RSCR_PG_FAULT_MS = 14;
    localparam int RSCR_PG_FAULT_CYCLES = RSCR_PG_FAULT_MS * 1000 * RSCR_CLK_MHZ;
    // Product variants: base, first, second
    typedef enum logic [1:0] {
        RSCR_VAR_BASE,
        RSCR_VAR_FIRST,
        RSCR_VAR_SECOND
    } rscr_variant_t;
endpackage

// ---- rtl/rscr_regs.sv ----
// Purpose: Command registers for rail enables, start-up and reference/slew.
// Assumes: Writes arrive as held sub-address/data pairs with a commit pulse.
// Notes: Held data is invisible to the rails until the commit pulse.
`timescale 1ns/1ns
`default_nettype none

// Function
// - Software-control bit low: rail enabled by its pin OR its register bit.
// - Software-control bit high: pins ignored, rail follows register bit only.
// - Base variant: mask bit 0 allows hard shutdown, 1 inhibits it.
// - Base/first: start-up bit 0 holds enable until output below 300mV.
// - Base/first: start-up bit 1 enables at once, discharge resistor off.
// - First/second: mask bit polarity reversed, 0 inhibits, 1 allows shutdown.
// - Second: start-up bit 0 no wait, 1 waits for discharge below 300mV.
// - Start-up register at 0x12, resets zero, bits 6..0 map to the rails.
// - Reference/slew register at 0x20, zero reset, select/start bit pairs per rail.
// - Power-on input low clears the whole rail enable register.
// - Mask acts only on faults beyond 14ms, never on fault reporting.
// - Written pairs go to holding latches, committed on STOP.
module rscr_regs #(
    parameter rscr_pkg::rscr_variant_t VARIANT = rscr_pkg::RSCR_VAR_BASE,
    parameter int PG_FAULT_CYCLES = rscr_pkg::RSCR_PG_FAULT_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_ce,
    input wire logic i_wr_valid,
    input wire logic [7:0] i_wr_addr,
    input wire logic [7:0] i_wr_data,
    input wire logic i_stop,
    input wire logic [7:0] i_rd_addr,
    input wire logic i_power_on_input,
    input wire logic i_buck1_enable_pin,
    input wire logic i_buck2_enable_pin,
    input wire logic i_buck3_enable_pin,
    input wire logic i_buckboost_enable_pin,
    input wire logic i_linreg2_enable_pin,
    input wire logic i_linreg34_enable_pin,
    input wire logic [6:0] i_below_threshold,
    input wire logic i_power_good,
    output logic [7:0] o_rd_data,
    output logic [6:0] o_rail_enable,
    output logic [6:0] o_discharge_on,
    output logic o_hard_shutdown,
    output logic [7:0] o_reference_slew_control,
    output logic o_power_good
);
    import rscr_pkg::*;

    localparam int CW = $clog2(PG_FAULT_CYCLES + 1);
    localparam logic [CW-1:0] FAULT_LIMIT = CW'(PG_FAULT_CYCLES);

    logic [7:0] rail_enable_reg;
    logic [7:0] rail_startup_control;
    logic [7:0] reference_slew_control;
    logic [7:0] hold_enable;
    logic [7:0] hold_startup;
    logic [7:0] hold_ref_slew;
    logic [2:0] hold_dirty;
    logic [6:0] pins;
    logic [6:0] requested;
    logic [6:0] wait_sel;
    logic [6:0] next_rail_enable;
    logic shutdown_allowed;
    logic [CW-1:0] fault_count;

    // Holding latches take each pair; a dirty bit per register marks it for the next STOP
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            hold_enable <= RSCR_RESET_RAIL_ENABLE;
            hold_startup <= RSCR_RESET_STARTUP;
            hold_ref_slew <= RSCR_RESET_REF_SLEW;
            hold_dirty <= 3'h0;
        end else if (i_ce) begin
            if (i_stop) begin
                hold_dirty <= 3'h0;
            end
            if (i_wr_valid) begin
                if (i_wr_addr == RSCR_ADDR_RAIL_ENABLE) begin
                    hold_enable <= i_wr_data;
                    hold_dirty[0] <= 1'b1;
                end else if (i_wr_addr == RSCR_ADDR_STARTUP) begin
                    hold_startup <= i_wr_data;
                    hold_dirty[1] <= 1'b1;
                end else if (i_wr_addr == RSCR_ADDR_REF_SLEW) begin
                    hold_ref_slew <= i_wr_data;
                    hold_dirty[2] <= 1'b1;
                end
            end
        end
    end

    // Rail enable register: power-on low beats any pending commit
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            rail_enable_reg <= RSCR_RESET_RAIL_ENABLE;
        end else if (i_ce) begin
            if (!i_power_on_input) begin
                rail_enable_reg <= RSCR_RESET_RAIL_ENABLE;
            end else if (i_stop && hold_dirty[0]) begin
                rail_enable_reg <= hold_enable;
            end
        end
    end

    // Start-up and reference/slew registers, committed on STOP only
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            rail_startup_control <= RSCR_RESET_STARTUP;
            reference_slew_control <= RSCR_RESET_REF_SLEW;
        end else if (i_ce && i_stop) begin
            if (hold_dirty[1]) begin
                rail_startup_control <= hold_startup;
            end
            if (hold_dirty[2]) begin
                reference_slew_control <= hold_ref_slew;
            end
        end
    end

    // Readback shows held data so software can verify before STOP
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_rd_data <= 8'h00;
        end else if (i_ce) begin
            if (i_rd_addr == RSCR_ADDR_RAIL_ENABLE) begin
                o_rd_data <= hold_dirty[0] ? hold_enable : rail_enable_reg;
            end else if (i_rd_addr == RSCR_ADDR_STARTUP) begin
                o_rd_data <= hold_dirty[1] ? hold_startup : rail_startup_control;
            end else if (i_rd_addr == RSCR_ADDR_REF_SLEW) begin
                o_rd_data <= hold_dirty[2] ? hold_ref_slew : reference_slew_control;
            end else begin
                o_rd_data <= 8'h00;
            end
        end
    end

    // Pin vector in register bit order; one pin serves both upper linear rails
    assign pins = {i_linreg34_enable_pin, i_linreg34_enable_pin, i_linreg2_enable_pin,
                   i_buckboost_enable_pin, i_buck3_enable_pin, i_buck2_enable_pin,
                   i_buck1_enable_pin};

    // Software-control bit picks register-only or pin-OR-register
    always_comb begin
        if (rail_enable_reg[RSCR_SW_CTRL_BIT]) begin
            requested = rail_enable_reg[6:0];
        end else begin
            requested = rail_enable_reg[6:0] | pins;
        end
    end

    // Second variant waits on a set bit, the others on a clear bit
    always_comb begin
        if (VARIANT == RSCR_VAR_SECOND) begin
            wait_sel = rail_startup_control[6:0];
        end else begin
            wait_sel = ~rail_startup_control[6:0];
        end
    end

    // Per-rail start gating; an already running rail stays on
    genvar g;
    generate
        for (g = 0; g < RSCR_NUM_RAILS; g++) begin : g_rail
            always_comb begin
                if (!requested[g]) begin
                    next_rail_enable[g] = 1'b0;
                end else if (o_rail_enable[g] || !wait_sel[g]) begin
                    next_rail_enable[g] = 1'b1;
                end else begin
                    next_rail_enable[g] = i_below_threshold[g];
                end
            end
        end
    endgenerate

    // Rail outputs and discharge resistor control, registered
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_rail_enable <= 7'h00;
            o_discharge_on <= 7'h7f;
            o_reference_slew_control <= RSCR_RESET_REF_SLEW;
        end else if (i_ce) begin
            o_rail_enable <= next_rail_enable;
            o_reference_slew_control <= reference_slew_control;
            if (VARIANT == RSCR_VAR_SECOND) begin
                o_discharge_on <= 7'h7f;
            end else begin
                o_discharge_on <= ~rail_startup_control[6:0];
            end
        end
    end

    // Mask polarity: base allows on 0, later variants allow on 1
    assign shutdown_allowed = (VARIANT == RSCR_VAR_BASE) ?
        !rail_startup_control[RSCR_HS_MASK_BIT] :
        rail_startup_control[RSCR_HS_MASK_BIT];

    // Fault timer runs regardless of the mask; only shutdown is masked
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            fault_count <= '0;
            o_hard_shutdown <= 1'b0;
            o_power_good <= 1'b0;
        end else if (i_ce) begin
            o_power_good <= i_power_good;
            if (i_power_good) begin
                fault_count <= '0;
            end else if (fault_count != FAULT_LIMIT) begin
                fault_count <= fault_count + CW'(1);
            end
            if (shutdown_allowed && !i_power_good && fault_count == FAULT_LIMIT) begin
                o_hard_shutdown <= 1'b1;
            end else if (i_power_good) begin
                o_hard_shutdown <= 1'b0;
            end
        end
    end
endmodule

`default_nettype wire

// ---- verification/rscr_host_model.sv ----
// Purpose: Host side writing sub-address/data pairs and STOP.
// Assumes: Serial framing already decoded into strobes.
// Notes: Strobes change on the falling edge.
`timescale 1ns/1ns
`default_nettype none
module rscr_host_model (
    input wire logic i_clk,
    output logic o_wr_valid,
    output logic [7:0] o_wr_addr,
    output logic [7:0] o_wr_data,
    output logic o_stop
);
    initial begin
        o_wr_valid = 1'h0;
        o_wr_addr = 8'h00;
        o_wr_data = 8'h00;
        o_stop = 1'h0;
    end
    // One pair, then the lines show stale inverted garbage
    task automatic put(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_clk);
        o_wr_valid = 1'h1;
        o_wr_addr = a;
        o_wr_data = d;
        @(negedge i_clk);
        o_wr_valid = 1'h0;
        o_wr_addr = ~a;
        o_wr_data = ~d;
    endtask
    // Never in the cycle of a pair, or the pair stays held until the next STOP
    task automatic fin();
        @(negedge i_clk);
        o_stop = 1'h1;
        @(negedge i_clk);
        o_stop = 1'h0;
    endtask
endmodule
`default_nettype wire

// ---- verification/rscr_regs_asserts.sv ----
// Purpose: Port checks for the start-up control bank.
// Assumes: Clock enable held high.
// Notes: Bound to rscr_regs below the checker.
`timescale 1ns/1ns
`default_nettype none
module rscr_regs_chk #(
    parameter int PG_FAULT_CYCLES = 20
) (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_stop,
    input wire logic [7:0] i_rd_addr,
    input wire logic i_power_good,
    input wire logic [7:0] o_rd_data,
    input wire logic [6:0] o_discharge_on,
    input wire logic o_hard_shutdown,
    input wire logic [7:0] o_reference_slew_control,
    input wire logic o_power_good
);
    int low_cnt;
    // Length of the current fault; a good sample restarts it
    always_ff @(posedge i_clk) begin
        low_cnt <= (!i_resetn || i_power_good) ? 0 : low_cnt + 1;
    end
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_resetn);
    pg_copy_a: assert property ($past(i_resetn) |-> o_power_good == $past(i_power_good))
        else $error("power good copy wrong");
    ref_commit_a: assert property ($changed(o_reference_slew_control) |-> $past(i_stop, 2))
        else $error("reference slew changed without stop");
    dis_commit_a: assert property ($changed(o_discharge_on) |-> $past(i_stop, 2))
        else $error("discharge changed without stop");
    hs_wait_a: assert property ($rose(o_hard_shutdown) |-> low_cnt >= PG_FAULT_CYCLES - 1)
        else $error("shutdown before fault time");
    hs_cause_a: assert property ($rose(o_hard_shutdown) |-> !$past(i_power_good))
        else $error("shutdown without fault");
    hs_sticky_a: assert property (o_hard_shutdown && !i_power_good |=> o_hard_shutdown)
        else $error("shutdown dropped during fault");
    hs_clear_a: assert property (o_hard_shutdown && i_power_good |-> ##[1:3] !o_hard_shutdown)
        else $error("shutdown stuck after recovery");
    rd_unmapped_a: assert property (!(i_rd_addr inside {8'h10, 8'h12, 8'h20}) |=> o_rd_data == 8'h00)
        else $error("unmapped read not zero");
endmodule
bind rscr_regs rscr_regs_chk #(.PG_FAULT_CYCLES(PG_FAULT_CYCLES)) rscr_regs_chk_i (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_stop(i_stop), .i_rd_addr(i_rd_addr),
    .i_power_good(i_power_good), .o_rd_data(o_rd_data), .o_discharge_on(o_discharge_on),
    .o_hard_shutdown(o_hard_shutdown), .o_reference_slew_control(o_reference_slew_control),
    .o_power_good(o_power_good));
`default_nettype wire

// ---- verification/tb_rscr_regs.sv ----
// Purpose: Directed tests of the start-up control bank.
// Assumes: Base variant, short fault time of 20 cycles.
// Notes: Inputs change on the falling edge.
`timescale 1ns/1ns
`default_nettype none
module tb_rscr_regs;
    logic clk = 1'h0, resetn = 1'h0, power_on_input = 1'h1, pg = 1'h1, wv, stp, hs, pgo;
    logic ce = 1'h1;
    logic [5:0] pins = 6'h00;
    logic [6:0] thr = 7'h7f, rail, dis;
    logic [7:0] rd_addr = 8'h00, rd_data, ref_sl, wa, wd;
    int error_cnt = 0, compares = 0;
    rscr_host_model rscr_host_model_i (.i_clk(clk), .o_wr_valid(wv), .o_wr_addr(wa),
        .o_wr_data(wd), .o_stop(stp));
    rscr_regs #(.PG_FAULT_CYCLES(20)) rscr_regs_i (.i_clk(clk), .i_resetn(resetn), .i_ce(ce),
        .i_wr_valid(wv), .i_wr_addr(wa), .i_wr_data(wd), .i_stop(stp), .i_rd_addr(rd_addr),
        .i_power_on_input(power_on_input), .i_buck1_enable_pin(pins[0]), .i_buck2_enable_pin(pins[1]),
        .i_buck3_enable_pin(pins[2]), .i_buckboost_enable_pin(pins[3]),
        .i_linreg2_enable_pin(pins[4]), .i_linreg34_enable_pin(pins[5]),
        .i_below_threshold(thr), .i_power_good(pg), .o_rd_data(rd_data), .o_rail_enable(rail),
        .o_discharge_on(dis), .o_hard_shutdown(hs), .o_reference_slew_control(ref_sl),
        .o_power_good(pgo));
    always #5 clk = ~clk;
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask
    // Registered outputs need a few edges to land
    task automatic settle();
        repeat (3) @(negedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        rd_addr = a;
        repeat (2) @(negedge clk);
        chk(rd_data, exp);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        rscr_host_model_i.put(a, d);
        rscr_host_model_i.fin();
        settle();
    endtask
    task automatic conclude();
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Tests need well under 1000 cycles
    initial begin
        #100000;
        error_cnt++;
        conclude();
    end
    initial begin
        repeat (10) @(negedge clk);
        resetn = 1'h1;
        rd(8'h12, 8'h00);
        rd(8'h20, 8'h00);
        rd(8'h33, 8'h00);
        chk({1'h0, dis}, 8'h7f);
        $display("reset test done");
        rscr_host_model_i.put(8'h20, 8'ha5);
        rd(8'h20, 8'ha5);
        chk(ref_sl, 8'h00);
        rscr_host_model_i.fin();
        settle();
        chk(ref_sl, 8'ha5);
        $display("commit test done");
        // Clock enable low: a full pair and STOP must leave no trace
        ce = 1'h0;
        rscr_host_model_i.put(8'h20, 8'h5a);
        rscr_host_model_i.fin();
        settle();
        chk(ref_sl, 8'ha5);
        ce = 1'h1;
        rd(8'h20, 8'ha5);
        $display("freeze test done");
        wr(8'h10, 8'h81);
        pins = 6'h02;
        settle();
        chk({1'h0, rail}, 8'h01);
        wr(8'h10, 8'h01);
        chk({1'h0, rail}, 8'h03);
        thr = 7'h7b;
        pins = 6'h06;
        settle();
        chk({1'h0, rail}, 8'h03);
        thr = 7'h7f;
        settle();
        chk({1'h0, rail}, 8'h07);
        wr(8'h12, 8'h08);
        chk({1'h0, dis}, 8'h77);
        thr = 7'h77;
        pins = 6'h0e;
        settle();
        chk({1'h0, rail}, 8'h0f);
        power_on_input = 1'h0;
        rd(8'h10, 8'h00);
        power_on_input = 1'h1;
        $display("enable test done");
        wr(8'h12, 8'h00);
        pg = 1'h0;
        repeat (25) @(negedge clk);
        chk({7'h00, hs}, 8'h01);
        pg = 1'h1;
        settle();
        chk({7'h00, hs}, 8'h00);
        wr(8'h12, 8'h80);
        pg = 1'h0;
        repeat (25) @(negedge clk);
        chk({6'h00, hs, pgo}, 8'h00);
        pg = 1'h1;
        $display("shutdown test done");
        conclude();
    end
endmodule
`default_nettype wire
